// ===== pkg/dscp_pkg.sv
// Shared constants and types for the serial configuration port, both ends.
// Assumes both ends run on clk_sys at 20 MHz and see the link through dscp_if.
package dscp_pkg;

   // ****************************************
   // Instruction byte layout
   // ****************************************
   localparam int INSTR_DIR_BIT    = 7;
   localparam int INSTR_CNT_HI     = 6;
   localparam int INSTR_CNT_LO     = 5;
   localparam int INSTR_ADDR_HI    = 4;
   localparam int INSTR_ADDR_LO    = 0;
   localparam int ADDR_W           = 5;
   localparam int BYTE_W           = 8;
   localparam int NUM_REGS         = 32;

   // ****************************************
   // Device configuration register zero
   // ****************************************
   localparam logic [4:0] CFG_REG_ADDR    = 5'h00;
   localparam int         CFG_ORDER_BIT   = 6;
   localparam logic [7:0] CFG_RESET_VALUE = 8'h00;
   localparam logic [4:0] ADDR_FLOOR      = 5'h00;
   localparam logic [4:0] ADDR_CEIL       = 5'h1F;

   // ****************************************
   // Host register map (Avalon word addresses)
   // ****************************************
   localparam logic [1:0] HOST_CTRL_ADDR   = 2'h0;
   localparam logic [1:0] HOST_STATUS_ADDR = 2'h1;
   localparam logic [1:0] HOST_WDATA_ADDR  = 2'h2;
   localparam logic [1:0] HOST_RDATA_ADDR  = 2'h3;
   // Control word fields: start bit, instruction byte, order, port reset.
   localparam int CTRL_START_BIT   = 0;
   localparam int CTRL_LSBF_BIT    = 1;
   localparam int CTRL_PRST_BIT    = 2;
   localparam int CTRL_INSTR_LO    = 8;
   localparam int STAT_BUSY_BIT    = 0;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_SYS_HZ       = 20_000_000;
   localparam int SCLK_MAX_HZ      = 20_000_000;
   // Host divider: half period in clk_sys cycles, 400 ns link period.
   localparam int SCLK_HALF_CYC    = 4;

   typedef enum logic [1:0] {DSCP_DIR_WRITE, DSCP_DIR_READ} dscp_dummy_t;

endpackage : dscp_pkg

// ===== pkg/dscp_if.sv
// Link between the serial configuration port and its host.
// Resolves the shared data wire itself from both enables; the host end wins if both drive.
`timescale 1ns/1ps
interface dscp_if;
   logic sclk;
   logic sel_n;
   logic hw_clear;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   logic sdio;

   // Pulled low when no end drives the wire.
   assign sdio = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b0);

   modport device (input sclk, input sel_n, input hw_clear, input sdio,
                   output sdio_dev_o, output sdio_dev_oe);
   modport host (output sclk, output sel_n, output hw_clear, input sdio,
                 output sdio_host_o, output sdio_host_oe);
endinterface : dscp_if

// ===== rtl/dscp_device.sv
// Device end of the serial configuration port with its 32-byte register file.
// Assumes link pins arrive asynchronously and the host keeps select low for a whole cycle.
//
// What this block does
// - Eight rising edges shift instruction, then data.
// - Instruction sets direction, count and start address.
// - Clear pin pulse returns to instruction phase.
// - Clear mid-cycle discards partial data, commits nothing.
// - Data phase moves exactly one to four bytes.
// - Write commits at each byte's last bit.
// - Instruction bit seven high means read.
// - Bits six and five give count minus one.
// - Bits four to zero give register address.
// - Instruction address serves first byte only.
// - Later addresses generated, direction from order bit.
// - One shared data pin, either bit order.
// - Host prefers multibyte transfers.
// - Sample on rising, drive on falling edges.
// - Select gates cycle; pin floats while high.
// - Address decrements in MSB-first, increments LSB-first.
// - Order bit resets to zero, MSB first.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module dscp_device #(
   parameter int SYNC_STAGES = 2
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   dscp_if.device          link,
   input  wire logic [4:0] reg_rd_addr,
   output logic      [7:0] reg_rd_data,
   output logic            lsb_first
);

   // The synchroniser depth is fixed by the two-bit fields of the state struct.
   if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("dscp_device: SYNC_STAGES must be 2");
   end

   typedef enum logic [1:0] {DSCP_INSTR, DSCP_DATA, DSCP_DONE} dscp_phase_t;

   typedef struct packed {
      logic [1:0]  sclk_s;
      logic [1:0]  sel_s;
      logic [1:0]  clr_s;
      logic [1:0]  sdio_s;
      logic        sclk_d;
      logic        clr_d;
      dscp_phase_t phase;
      logic [2:0]  bit_cnt;
      logic [7:0]  shift;
      logic        rd;
      logic [1:0]  bytes_left;
      logic [4:0]  addr;
      logic        order_lsb;
      logic [7:0]  tx;
      logic        sdo;
      logic        sdo_oe;
      logic [7:0]  rd_data;
   } dscp_dev_state_t;

   dscp_dev_state_t st_reg, st_next;
   logic [7:0] regs_reg [0:dscp_pkg::NUM_REGS-1];
   logic       wr_en;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;

   // Assemble a received byte into register order given the current bit order.
   function automatic logic [7:0] dscp_order(input logic [7:0] b, input logic lsbf);
      logic [7:0] r;
      r = b;
      if (lsbf) begin
         for (int i = 0; i < 8; i++) r[i] = b[7-i];
      end
      return r;
   endfunction : dscp_order

   // Next address after a byte; saturates at the ends of the map.
   function automatic logic [4:0] dscp_step(input logic [4:0] a, input logic lsbf);
      logic [4:0] r;
      r = a;
      if (lsbf) begin
         if (a != dscp_pkg::ADDR_CEIL) r = a + 5'h01;
      end else begin
         if (a != dscp_pkg::ADDR_FLOOR) r = a - 5'h01;
      end
      return r;
   endfunction : dscp_step

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      logic       rise;
      logic       fall;
      logic       clr_fall;
      logic [7:0] byte_in;
      logic [7:0] instr;
      rise     = 1'b0;
      fall     = 1'b0;
      clr_fall = 1'b0;
      byte_in  = 8'h00;
      instr    = 8'h00;
      st_next  = st_reg;
      wr_en    = 1'b0;
      wr_addr  = st_reg.addr;
      wr_data  = 8'h00;

      // Only the second synchroniser stage is read below.
      st_next.sclk_s = {st_reg.sclk_s[0], link.sclk};
      st_next.sel_s  = {st_reg.sel_s[0], link.sel_n};
      st_next.clr_s  = {st_reg.clr_s[0], link.hw_clear};
      st_next.sdio_s = {st_reg.sdio_s[0], link.sdio};
      st_next.sclk_d = st_reg.sclk_s[1];
      st_next.clr_d  = st_reg.clr_s[1];
      rise     = st_reg.sclk_s[1] & ~st_reg.sclk_d;
      fall     = ~st_reg.sclk_s[1] & st_reg.sclk_d;
      clr_fall = st_reg.clr_d & ~st_reg.clr_s[1];

      byte_in = {st_reg.shift[6:0], st_reg.sdio_s[1]};
      instr   = dscp_order(byte_in, st_reg.order_lsb);

      if (st_reg.sel_s[1] || st_reg.clr_s[1] || clr_fall) begin
         st_next.phase   = DSCP_INSTR;
         st_next.bit_cnt = 3'h0;
         st_next.sdo_oe  = 1'b0;
      end else if (rise) begin
         st_next.shift   = byte_in;
         st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
         case (st_reg.phase)
            DSCP_INSTR: begin
               if (st_reg.bit_cnt == 3'h7) begin
                  st_next.phase      = DSCP_DATA;
                  st_next.rd         = instr[dscp_pkg::INSTR_DIR_BIT];
                  st_next.bytes_left = instr[dscp_pkg::INSTR_CNT_HI:dscp_pkg::INSTR_CNT_LO];
                  st_next.addr       = instr[dscp_pkg::INSTR_ADDR_HI:dscp_pkg::INSTR_ADDR_LO];
                  st_next.tx         = dscp_order(regs_reg[instr[4:0]], st_reg.order_lsb);
               end
            end
            DSCP_DATA: begin
               if (st_reg.bit_cnt == 3'h7) begin
                  if (!st_reg.rd) begin
                     wr_en   = 1'b1;
                     wr_data = instr;
                  end
                  st_next.addr = dscp_step(st_reg.addr, st_reg.order_lsb);
                  st_next.tx   = dscp_order(regs_reg[dscp_step(st_reg.addr, st_reg.order_lsb)],
                                            st_reg.order_lsb);
                  if (st_reg.bytes_left == 2'h0) begin
                     st_next.phase = DSCP_DONE;
                  end else begin
                     st_next.bytes_left = st_reg.bytes_left - 2'h1;
                  end
                  if (wr_en && st_reg.addr == dscp_pkg::CFG_REG_ADDR) begin
                     st_next.order_lsb = instr[dscp_pkg::CFG_ORDER_BIT];
                  end
               end
            end
            DSCP_DONE: begin
               st_next.bit_cnt = st_reg.bit_cnt;
            end
            default: st_next.phase = DSCP_INSTR;
         endcase
      end else if (fall) begin
         if (st_reg.phase == DSCP_DATA && st_reg.rd) begin
            st_next.sdo    = st_reg.tx[7];
            st_next.tx     = {st_reg.tx[6:0], 1'b0};
            st_next.sdo_oe = 1'b1;
         end else begin
            st_next.sdo_oe = 1'b0;
         end
      end
      st_next.rd_data = regs_reg[reg_rd_addr];
   end

   // ****************************************
   // State and register file
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg           <= '0;
         st_reg.phase     <= DSCP_INSTR;
         st_reg.order_lsb <= dscp_pkg::CFG_RESET_VALUE[dscp_pkg::CFG_ORDER_BIT];
         for (int i = 0; i < dscp_pkg::NUM_REGS; i++) regs_reg[i] <= 8'h00;
      end else begin
         st_reg <= st_next;
         if (wr_en) regs_reg[wr_addr] <= wr_data;
      end
   end

   assign link.sdio_dev_o  = st_reg.sdo;
   assign link.sdio_dev_oe = st_reg.sdo_oe;
   assign reg_rd_data      = st_reg.rd_data;
   assign lsb_first        = st_reg.order_lsb;

endmodule : dscp_device

// ===== rtl/dscp_host.sv
// Host end: Avalon-MM slave registers drive one serial cycle per start.
// Assumes the device samples on rising and drives on falling serial edges.
`timescale 1ns/1ps
module dscp_host (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   dscp_if.host             link,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest
);

   typedef enum logic [1:0] {DSCPH_IDLE, DSCPH_SHIFT, DSCPH_END} dscph_state_t;

   typedef struct packed {
      dscph_state_t st;
      logic [1:0]   sdio_s;
      logic [2:0]   div;
      logic         sclk;
      logic         sel_n;
      logic         clr;
      logic         lsbf;
      logic [7:0]   instr;
      logic [31:0]  wdata;
      logic [31:0]  rdata;
      logic [39:0]  tx;
      logic [5:0]   bits_left;
      logic         dout;
      logic         doe;
      logic [31:0]  rdout;
      logic         wait_n;
   } dscph_state_s_t;

   dscph_state_s_t s_reg, s_next;

   function automatic logic [7:0] dscph_rev(input logic [7:0] b);
      logic [7:0] r;
      r = b;
      for (int i = 0; i < 8; i++) r[i] = b[7-i];
      return r;
   endfunction : dscph_rev

   always_comb begin
      logic [5:0] total;
      logic       rd;
      logic [5:0] dbits;
      total  = 6'h00;
      rd     = s_reg.instr[dscp_pkg::INSTR_DIR_BIT];
      dbits  = {1'b0, s_reg.instr[dscp_pkg::INSTR_CNT_HI:dscp_pkg::INSTR_CNT_LO], 3'b000} + 6'h08;
      s_next = s_reg;
      s_next.sdio_s = {s_reg.sdio_s[0], link.sdio};
      // One-cycle answer: waitrequest low in the cycle after a request.
      s_next.wait_n = (avs_read | avs_write) & ~s_reg.wait_n;
      s_next.clr    = 1'b0;
      if (avs_read && !s_reg.wait_n) begin
         case (avs_address)
            dscp_pkg::HOST_CTRL_ADDR:   s_next.rdout = {16'h0000, s_reg.instr, 6'h00, s_reg.lsbf, 1'b0};
            dscp_pkg::HOST_STATUS_ADDR: s_next.rdout = {31'h0, s_reg.st != DSCPH_IDLE};
            dscp_pkg::HOST_WDATA_ADDR:  s_next.rdout = s_reg.wdata;
            // Bytes arrive bit-reversed in LSB-first order, so they are handed back in register order.
            default:                    s_next.rdout = s_reg.lsbf
               ? {dscph_rev(s_reg.rdata[31:24]), dscph_rev(s_reg.rdata[23:16]),
                  dscph_rev(s_reg.rdata[15:8]), dscph_rev(s_reg.rdata[7:0])}
               : s_reg.rdata;
         endcase
      end
      case (s_reg.st)
         DSCPH_IDLE: begin
            // A write lands only at the edge where the master sees waitrequest low.
            if (avs_write && s_reg.wait_n) begin
               if (avs_address == dscp_pkg::HOST_WDATA_ADDR) s_next.wdata = avs_writedata;
               if (avs_address == dscp_pkg::HOST_CTRL_ADDR) begin
                  s_next.lsbf  = avs_writedata[dscp_pkg::CTRL_LSBF_BIT];
                  s_next.instr = avs_writedata[dscp_pkg::CTRL_INSTR_LO +: 8];
                  s_next.clr   = avs_writedata[dscp_pkg::CTRL_PRST_BIT];
                  if (avs_writedata[dscp_pkg::CTRL_START_BIT]) begin
                     total = {1'b0, avs_writedata[dscp_pkg::CTRL_INSTR_LO+6 -: 2], 3'b000} + 6'd16;
                     s_next.bits_left = total;
                     s_next.st        = DSCPH_SHIFT;
                     s_next.sel_n     = 1'b0;
                     s_next.div       = 3'h0;
                     s_next.rdata     = 32'h0;
                     s_next.tx = avs_writedata[dscp_pkg::CTRL_LSBF_BIT]
                        ? {dscph_rev(avs_writedata[15:8]), dscph_rev(s_reg.wdata[31:24]),
                           dscph_rev(s_reg.wdata[23:16]), dscph_rev(s_reg.wdata[15:8]),
                           dscph_rev(s_reg.wdata[7:0])}
                        : {avs_writedata[15:8], s_reg.wdata};
                     s_next.dout = s_next.tx[39];
                     s_next.doe  = 1'b1;
                  end
               end
            end
         end
         DSCPH_SHIFT: begin
            s_next.div = s_reg.div + 3'h1;
            if (s_reg.div == 3'(dscp_pkg::SCLK_HALF_CYC - 1)) begin
               s_next.div  = 3'h0;
               s_next.sclk = ~s_reg.sclk;
               if (!s_reg.sclk) begin
                  s_next.bits_left = s_reg.bits_left - 6'h01;
               end else begin
                  // The device's bit returns through two synchronisers on each side, so it settles
                  // only one clk_sys cycle after our rising edge; it is taken at our falling edge, before the device moves on.
                  if (rd && s_reg.bits_left < dbits) s_next.rdata = {s_reg.rdata[30:0], s_reg.sdio_s[1]};
                  s_next.tx   = {s_reg.tx[38:0], 1'b0};
                  s_next.dout = s_reg.tx[38];
                  s_next.doe  = ~(rd && s_reg.bits_left <= dbits);
                  if (s_reg.bits_left == 6'h00) begin
                     s_next.st  = DSCPH_END;
                     s_next.doe = 1'b0;
                  end
               end
            end
         end
         DSCPH_END: begin
            s_next.sel_n = 1'b1;
            s_next.st    = DSCPH_IDLE;
         end
         default: s_next.st = DSCPH_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg       <= '0;
         s_reg.st    <= DSCPH_IDLE;
         s_reg.sel_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign link.sclk         = s_reg.sclk;
   assign link.sel_n        = s_reg.sel_n;
   assign link.hw_clear     = s_reg.clr;
   assign link.sdio_host_o  = s_reg.dout;
   assign link.sdio_host_oe = s_reg.doe;
   assign avs_readdata      = s_reg.rdout;
   assign avs_waitrequest   = ~s_reg.wait_n;

endmodule : dscp_host

// ===== verification/dscp_properties.sv
// Concurrent checks on the serial link between the host end and the device end.
// Assumes clk_sys samples every link signal and rst is synchronous, active high.
`timescale 1ns/1ps
module dscp_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic hw_clear,
   input wire logic sdio_host_oe,
   input wire logic sdio_dev_o,
   input wire logic sdio_dev_oe,
   input wire logic sdio
);
   // ****************************************
   // Frame tracking
   // ****************************************
   logic [5:0] rise_cnt_reg;
   logic       sclk_q_reg;
   logic       first_bit_reg;
   logic       last_bit_reg;

   // The direction flag is the first bit in one order and the last in the other, so both are kept.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rise_cnt_reg  <= 6'h00;
         sclk_q_reg    <= 1'b0;
         first_bit_reg <= 1'b0;
         last_bit_reg  <= 1'b0;
      end else begin
         sclk_q_reg <= sclk;
         if (sel_n) begin
            rise_cnt_reg <= 6'h00;
         end else if (sclk && !sclk_q_reg) begin
            rise_cnt_reg <= rise_cnt_reg + 6'h01;
            if (rise_cnt_reg == 6'h00) first_bit_reg <= sdio;
            if (rise_cnt_reg == 6'h07) last_bit_reg <= sdio;
         end
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_read_start;
      $rose(sdio_dev_oe);
   endsequence
   sequence s_frame_end;
      $rose(sel_n) && !hw_clear;
   endsequence

   chk_pin_float: assert property (sel_n [*6] |-> !sdio_dev_oe)
      else $error("device drives data while deselected");
   chk_clock_idle: assert property (sel_n && $past(sel_n) |-> !sclk)
      else $error("serial clock moves outside a frame");
   chk_one_driver: assert property (!(sdio_host_oe && sdio_dev_oe))
      else $error("both ends drive the data wire");
   chk_clock_rate: assert property ($rose(sclk) |=> !$rose(sclk) [*7])
      else $error("serial clock faster than allowed");
   chk_drive_falling: assert property ($changed(sdio_dev_o) && sdio_dev_oe && $past(sdio_dev_oe) |-> !sclk)
      else $error("device data changes while serial clock high");
   chk_read_start: assert property (s_read_start |-> rise_cnt_reg == 6'd8)
      else $error("device drives before instruction complete");
   chk_read_dir: assert property (s_read_start |-> first_bit_reg || last_bit_reg)
      else $error("device answers a write instruction");
   chk_write_quiet: assert property (rise_cnt_reg > 6'd8 && !first_bit_reg && !last_bit_reg |-> !sdio_dev_oe)
      else $error("device drives during a write frame");
   chk_frame_len: assert property (s_frame_end |-> rise_cnt_reg inside {6'd16, 6'd24, 6'd32, 6'd40})
      else $error("frame length is not a whole byte count");
   chk_clear_release: assert property ($fell(hw_clear) |-> ##[0:4] !sdio_dev_oe)
      else $error("device still drives after port clear");
endmodule : dscp_properties

// ===== verification/dscp_tb.sv
// Self-checking bench joining host and device ends through one link.
// Assumes the host answers on Avalon-MM and the device exposes a debug read port.
`timescale 1ns/1ps
module dac_serial_config_port_tb;
   logic        clk_sys;
   logic        rst;
   logic [1:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [4:0]  reg_rd_addr;
   logic [7:0]  reg_rd_data;
   logic        lsb_first;
   logic [31:0] rd_word;
   int          num_errors;
   int          comparisons;

   dscp_if lnk ();
   dscp_host u_dscp_host (.clk_sys, .rst, .link(lnk), .avs_address, .avs_read, .avs_write,
                          .avs_writedata, .avs_readdata, .avs_waitrequest);
   dscp_device u_dscp_device (.clk_sys, .rst, .link(lnk), .reg_rd_addr, .reg_rd_data, .lsb_first);
   dscp_properties u_dscp_properties (.clk_sys, .rst, .sclk(lnk.sclk), .sel_n(lnk.sel_n),
      .hw_clear(lnk.hw_clear), .sdio_host_oe(lnk.sdio_host_oe), .sdio_dev_o(lnk.sdio_dev_o),
      .sdio_dev_oe(lnk.sdio_dev_oe), .sdio(lnk.sdio));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic close_out;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_byte

   task automatic bus(input logic [1:0] addr, input logic rd, input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      avs_address   <= addr;
      avs_read      <= rd;
      avs_write     <= !rd;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         num_errors++;
         close_out();
      end
      rd_word = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         bus(dscp_pkg::HOST_STATUS_ADDR, 1'b1, 32'h00000000);
         n++;
      end while (rd_word[0] !== 1'b0 && n < 500);
      if (n >= 500) begin
         num_errors++;
         close_out();
      end
   endtask : wait_idle

   task automatic start(input logic [7:0] instr, input logic [31:0] wd, input logic lsb);
      bus(dscp_pkg::HOST_WDATA_ADDR, 1'b0, wd);
      bus(dscp_pkg::HOST_CTRL_ADDR, 1'b0, {16'h0000, instr, 6'h00, lsb, 1'b1});
   endtask : start

   task automatic xfer(input logic [7:0] instr, input logic [31:0] wd, input logic lsb);
      start(instr, wd, lsb);
      wait_idle();
      bus(dscp_pkg::HOST_RDATA_ADDR, 1'b1, 32'h00000000);
   endtask : xfer

   task automatic peek(input logic [4:0] a, input logic [7:0] exp);
      reg_rd_addr <= a;
      repeat (2) @(posedge clk_sys);
      check_byte("register", exp, reg_rd_data);
   endtask : peek

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_counts;
      logic [4:0] a;
      for (int n = 0; n < 4; n++) begin
         a = 5'(12 + 5 * n);
         xfer({1'b0, 2'(n), a}, 32'h11223344, 1'b0);
         peek(a - 5'(n), 8'(8'h11 * (n + 1)));
         peek(a - 5'(n) - 5'h01, 8'h00);
      end
   endtask : t_counts

   task automatic t_read;
      xfer(8'hD6, 32'h00000000, 1'b0);
      check_byte("rdata", 8'h33, rd_word[7:0]);
      xfer(8'h8C, 32'h00000000, 1'b0);
      check_byte("rdata", 8'h11, rd_word[7:0]);
   endtask : t_read

   // A start while busy must be dropped, leaving the running frame intact.
   task automatic t_refuse;
      start(8'h03, 32'hAA000000, 1'b0);
      bus(dscp_pkg::HOST_STATUS_ADDR, 1'b1, 32'h00000000);
      check_byte("busy", 8'h01, {7'h00, rd_word[0]});
      start(8'h04, 32'h55000000, 1'b0);
      wait_idle();
      peek(5'h03, 8'hAA);
      peek(5'h04, 8'h00);
   endtask : t_refuse

   task automatic t_clear;
      bus(dscp_pkg::HOST_CTRL_ADDR, 1'b0, 32'h00000004);
      xfer(8'h05, 32'h5A000000, 1'b0);
      peek(5'h05, 8'h5A);
   endtask : t_clear

   task automatic t_order;
      xfer(8'h00, 32'h40000000, 1'b0);
      check_byte("order", 8'h01, {7'h00, lsb_first});
      xfer(8'h5E, 32'h33445500, 1'b1);
      peek(5'h1E, 8'h33);
      peek(5'h1F, 8'h55);
      xfer(8'h9F, 32'h00000000, 1'b1);
      check_byte("rdata", 8'h55, rd_word[7:0]);
      xfer(8'h00, 32'h00000000, 1'b1);
      check_byte("order", 8'h00, {7'h00, lsb_first});
   endtask : t_order

   // ****************************************
   // Run control
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      #2_000_000;
      num_errors++;
      close_out();
   end

   initial begin
      rst           = 1'b1;
      avs_address   = 2'h0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h00000000;
      reg_rd_addr   = 5'h00;
      num_errors    = 0;
      comparisons   = 0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      peek(5'h00, 8'h00);
      check_byte("order", 8'h00, {7'h00, lsb_first});
      t_counts();
      t_read();
      t_refuse();
      t_clear();
      t_order();
      close_out();
   end
endmodule : dac_serial_config_port_tb
